// >>> bench/adc_far_side.sv
// Purpose: far side model, comparator and serial receiver
// Assumes: receiver takes data on each pulse_chain rise
// Notes: a target past either end drives the count to that end
`timescale 1ns/100ps
module adc_far_side (
    input wire logic clk, // bench clock
    input wire logic nrst, // reset, active low
    input wire logic [9:0] par_out, // count from converter
    input wire logic ser_out, // serial data
    input wire logic pulse_chain, // receiver bit clock
    input wire logic cascade_out, // end of frame strobe
    input wire logic signed [11:0] target, // level in counts
    output logic dir_up, // comparator, high counts up
    output logic [10:0] frame_word, // last frame, parity bit 0
    output logic [3:0] frame_bits, // pulses in last frame
    output logic [7:0] frame_count, // frames seen
    output logic [7:0] casc_len // cascade width in clk
);
    logic [10:0] sh_q;
    logic [3:0] n_q;
    logic pc_q;
    logic cs_q;
    ////////////////////////////////////////////////////////////////
    // comparator sees the count as straight binary
    assign dir_up = $signed({2'b00, par_out}) < target;
    // shift on each pulse rise, close frame on cascade
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sh_q, n_q, pc_q, cs_q} <= '0;
            {frame_word, frame_bits, frame_count, casc_len} <= '0;
        end else begin
            pc_q <= pulse_chain;
            cs_q <= cascade_out;
            if (pulse_chain && !pc_q) begin
                sh_q <= {sh_q[9:0], ser_out};
                n_q <= n_q + 4'h1;
            end
            if (cascade_out && !cs_q) begin
                frame_word <= sh_q;
                frame_bits <= n_q;
                frame_count <= frame_count + 8'h01;
                casc_len <= 8'h01;
                sh_q <= '0;
                n_q <= '0;
            end else if (cascade_out) begin
                casc_len <= casc_len + 8'h01;
            end
        end
    end
endmodule

// >>> bench/tb_adc_tracking_counter_serial_tx.sv
// Purpose: self-checking bench for the tracking converter control
// Assumes: tx clock free running at 200 ns, unrelated phase
// Notes: a bench model of the count gives the count and frame data expectations
`timescale 1ns/100ps
module tb_adc_tracking_counter_serial_tx;
    import adc_ctl_pkg::*;
    logic clk = 0, nrst = 0, cnt_clk_pin = 0, tx_clk_pin = 0;
    logic load_in = 0, xmit_q = 0, chain_q = 0, even_par = 0, len8 = 0;
    logic read = 0, write = 0, waitrequest, dir_up, irq;
    logic [3:0] address = 0;
    logic [31:0] writedata = 0, readdata, rd, r, seed;
    logic [9:0] par_out, m, v, v2;
    logic ser_out, pulse_chain, data_avail, cascade_out, ldir, l8, ev, hold;
    logic signed [11:0] target = 0;
    logic [10:0] frame_word;
    logic [3:0] frame_bits;
    logic [7:0] frame_count, casc_len, was;
    int fail_count = 0, checks = 0;
    ////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    initial begin
        #13;
        forever #100 tx_clk_pin = ~tx_clk_pin;
    end
    adc_tracking_counter_serial_tx DUT (.clk, .nrst, .ce(1'b1),
        .cnt_clk_pin, .tx_clk_pin, .dir_up, .load_in,
        .xmit_in(xmit_q | (chain_q & cascade_out)), .even_par, .len8,
        .par_out, .ser_out, .pulse_chain, .data_avail, .cascade_out,
        .irq, .address, .read, .write, .writedata, .readdata,
        .waitrequest);
    adc_far_side far (.clk, .nrst, .par_out, .ser_out, .pulse_chain,
        .cascade_out, .target, .dir_up, .frame_word, .frame_bits,
        .frame_count, .casc_len);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected frame: data then parity, msb first
    function automatic logic [10:0] frame_of(logic [9:0] d, logic s, logic e);
        logic [9:0] x;
        x = s ? {2'b00, d[9:2]} : d;
        return {x, e ? ^x : ~^x};
    endfunction
    task final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task tmo(input string what);
        fail_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        final_report();
    endtask
    // avalon cycle, held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 16);
        if (waitrequest !== 1'b0) tmo("waitrequest");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task cmp_irq(input logic e);
        @(negedge clk);
        cmp("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // counter edges, wide enough for the pin synchronisers
    task edges(input int k, input logic signed [11:0] t);
        logic up;
        target <= t;
        repeat (6) @(posedge clk);
        repeat (k) begin
            up = $signed({2'b00, m}) < t;
            cnt_clk_pin <= 1'b1;
            repeat (3) @(posedge clk);
            cnt_clk_pin <= 1'b0;
            repeat (3) @(posedge clk);
            if (up !== ldir) ldir = up;
            else if (up && m != CNT_MAX && !hold) m = m + 10'h001;
            else if (!up && m != CNT_MIN && !hold) m = m - 10'h001;
        end
        repeat (4) @(posedge clk);
        cmp("par_out", {22'h0, m}, {22'h0, par_out});
    endtask
    task pulse_load();
        @(posedge clk);
        load_in <= 1'b1;
        repeat (3) @(posedge clk);
        load_in <= 1'b0;
    endtask
    task wait_frame(input logic [7:0] w);
        int n;
        for (n = 0; frame_count === w && n < 3000; n++) @(posedge clk);
        if (frame_count === w) tmo("frame");
        repeat (12) @(posedge clk);
    endtask
    task check_frame(input logic [9:0] d);
        cmp("word", {21'h0, frame_of(d, l8, ev)}, {21'h0, frame_word});
        cmp("pulses", l8 ? 32'h9 : 32'hB, {28'h0, frame_bits});
        cmp("cascade", 32'h8, {24'h0, casc_len});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h3d42_1983;
        m = 10'h000;
        ldir = 1'b0;
        hold = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0);
        cmp("ctrl", 32'h1, rd);
        bus(1'b0, OFF_IRQ_MASK, 32'h0);
        cmp("mask", 32'h0, rd);
        bus(1'b0, 4'h2, 32'h0);
        cmp("unmapped", 32'h0, rd);
        // run to both ends, where the count must hold
        edges(3, -12'sd1);
        edges(1100, 12'sd1024);
        edges(1100, -12'sd1);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            edges(int'(r[4:0]) + 1, {2'b00, r[31:22]});
            pulse_load();
            v = m;
            repeat (8) @(posedge clk);
            cmp("avail", 32'h1, {31'h0, data_avail});
            edges(3, {2'b00, r[21:12]});
            l8 = (i < 4) ? i[0] : r[5];
            ev = (i < 4) ? i[1] : r[6];
            len8 <= l8;
            even_par <= ev;
            was = frame_count;
            chain_q <= (i == 5);
            // request held one to eight tx periods
            xmit_q <= 1'b1;
            repeat (8 * ((i == 5) ? 3 : int'(r[9:7]) + 1)) @(posedge clk);
            xmit_q <= 1'b0;
            if (i == 5) pulse_load();
            v2 = m;
            wait_frame(was);
            check_frame(v);
            cmp("avail_end", {31'h0, i == 5}, {31'h0, data_avail});
        end
        // cascade looped to transmit sends the held load
        chain_q <= 1'b0;
        wait_frame(was + 8'h01);
        check_frame(v2);
        // register strobes: load then transmit, run bit kept set
        was = frame_count;
        bus(1'b1, OFF_CTRL, 32'h3);
        bus(1'b1, OFF_CTRL, 32'h5);
        wait_frame(was);
        check_frame(m);
        bus(1'b0, OFF_IRQ_STAT, 32'h0);
        cmp("irq_stat", 32'h7, rd);
        cmp_irq(1'b0);
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        cmp_irq(1'b1);
        bus(1'b1, OFF_IRQ_STAT, 32'h7);
        cmp_irq(1'b0);
        // run bit low stops the count, direction still tracked
        hold = 1'b1;
        bus(1'b1, OFF_CTRL, 32'h0);
        edges(5, 12'sd1024);
        hold = 1'b0;
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b0, OFF_STATUS, 32'h0);
        cmp("status", {22'h0, m}, {22'h0, rd[9:0]});
        cmp("par_out", {22'h0, m}, {22'h0, par_out});
        final_report();
    end
endmodule

// >>> src/adc_ctl_pkg.sv
// Purpose: shared constants for the tracking converter control block
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes: frame lengths count data bits plus the parity bit
package adc_ctl_pkg;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 4;
    localparam int FRAME_W = 11;
    // frame lengths: data bits plus parity
    localparam logic [3:0] BITS_SHORT = 4'h9;
    localparam logic [3:0] BITS_LONG = 4'hB;
    localparam logic [9:0] CNT_MIN = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3FF;
    // register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CTRL_XMIT_BIT = 2;
    localparam logic CTRL_RUN_RST = 1'b1;
    // status register fields
    localparam int ST_AVAIL_BIT = 16;
    localparam int ST_BUSY_BIT = 17;
    localparam int ST_PEND_BIT = 18;
    // interrupt event bits
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_LIMIT = 1;
    localparam int EV_LOADED = 2;
    localparam logic [2:0] MASK_RST = 3'h0;
    // synchronised pin index
    localparam int PIN_W = 5;
    localparam int PIN_DIR = 0;
    localparam int PIN_LOAD = 1;
    localparam int PIN_XMIT = 2;
    localparam int PIN_EVEN = 3;
    localparam int PIN_LEN8 = 4;
endpackage

// >>> src/adc_tracking_counter_serial_tx.sv
// Purpose: tracking converter counter and serial transmitter control
// Assumes: both pin clocks far slower than clk, sampled and edge detected
// Notes: registers over avalon-mm, one level interrupt output
//
// How it works
// - ten-bit up/down counter holds the result
// - counts up when direction high, else down
// - skip count on direction change or load
// - counter holds at all zeros or ones
// - load pulse copies counter into transmitter
// - load during transmission waits until it ends
// - data valid high from load until sent
// - transmit pulse starts sending loaded data
// - eight or ten bits, parity, msb first
// - word-length select high sends eight bits
// - parity select high gives even parity
// - pulse chain of nine or eleven pulses
// - cascade high one transmitter clock at end
// - straight binary, bit one is msb
`timescale 1ns/100ps
module adc_tracking_counter_serial_tx (
    input wire logic clk, // 40 mhz system clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic cnt_clk_pin, // counter clock pin
    input wire logic tx_clk_pin, // transmitter clock pin
    input wire logic dir_up, // comparator, high counts up
    input wire logic load_in, // load request pulse
    input wire logic xmit_in, // transmit request pulse
    input wire logic even_par, // high selects even parity
    input wire logic len8, // high selects eight data bits
    output logic [adc_ctl_pkg::CNT_W-1:0] par_out, // counter, [9] msb
    output logic ser_out, // serial data
    output logic pulse_chain, // receiver bit clock
    output logic data_avail, // valid data in transmitter
    output logic cascade_out, // end of transmission strobe
    output logic irq, // level interrupt
    input wire logic [adc_ctl_pkg::ADDR_W-1:0] address, // byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest // avalon stall
);
    import adc_ctl_pkg::*;

    typedef struct packed {
        logic cclk_m;
        logic cclk_s;
        logic cclk_p;
        logic tclk_m;
        logic tclk_s;
        logic tclk_p;
        logic [PIN_W-1:0] pin_m;
        logic [PIN_W-1:0] pin_s;
        logic load_p;
        logic xmit_p;
        logic [CNT_W-1:0] cnt;
        logic dir_last;
        logic [FRAME_W-1:0] shreg;
        logic [3:0] bits_left;
        logic busy;
        logic avail;
        logic pend_load;
        logic pend_xmit;
        logic ser;
        logic pulse;
        logic casc;
        logic run;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t s_q, s_d;

    // decode used for both reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin edges and bus strobes
    logic cedge, trise, tfall, load_ev, xmit_ev, wr_ok, rd_go;
    logic load_now, start_now, cnt_inhibit;
    logic [CNT_W-1:0] dword;
    assign cedge = s_q.cclk_s & ~s_q.cclk_p;
    assign trise = s_q.tclk_s & ~s_q.tclk_p;
    assign tfall = ~s_q.tclk_s & s_q.tclk_p;
    assign wr_ok = write & s_q.ack;
    assign rd_go = read & ~s_q.ack;
    // load on rising edge of request
    assign load_ev = (s_q.pin_s[PIN_LOAD] & ~s_q.load_p)
        | (wr_ok & hit(address, OFF_CTRL) & writedata[CTRL_LOAD_BIT]);
    // transmit on rising edge, width ignored
    assign xmit_ev = (s_q.pin_s[PIN_XMIT] & ~s_q.xmit_p)
        | (wr_ok & hit(address, OFF_CTRL) & writedata[CTRL_XMIT_BIT]);
    // a load waits while a frame is on the wire
    assign load_now = (load_ev | s_q.pend_load) & ~s_q.busy;
    // a frame never starts in the cycle that reloads its data
    assign start_now = trise & s_q.pend_xmit & s_q.avail & ~s_q.busy
        & ~load_now;
    // skip on direction change or load
    assign cnt_inhibit = (s_q.pin_s[PIN_DIR] != s_q.dir_last) | load_now
        | ~s_q.run;
    // short word keeps the eight upper bits
    assign dword = s_q.shreg[FRAME_W-1:1];

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        // write one clears first, so an event set below wins
        if (wr_ok && hit(address, OFF_IRQ_STAT))
            s_d.stat = s_q.stat & ~writedata[EV_W-1:0];
        // two-flop synchronisers, first stage read only by second
        s_d.cclk_m = cnt_clk_pin;
        s_d.cclk_s = s_q.cclk_m;
        s_d.cclk_p = s_q.cclk_s;
        s_d.tclk_m = tx_clk_pin;
        s_d.tclk_s = s_q.tclk_m;
        s_d.tclk_p = s_q.tclk_s;
        s_d.pin_m = {len8, even_par, xmit_in, load_in, dir_up};
        s_d.pin_s = s_q.pin_m;
        s_d.load_p = s_q.pin_s[PIN_LOAD];
        s_d.xmit_p = s_q.pin_s[PIN_XMIT];

        // counter
        if (cedge) begin
            s_d.dir_last = s_q.pin_s[PIN_DIR];
            if (!cnt_inhibit) begin
                if (s_q.pin_s[PIN_DIR]) begin
                    if (s_q.cnt != CNT_MAX)
                        s_d.cnt = s_q.cnt + 10'h001;
                    else
                        s_d.stat[EV_LIMIT] = 1'b1;
                end else begin
                    if (s_q.cnt != CNT_MIN)
                        s_d.cnt = s_q.cnt - 10'h001;
                    else
                        s_d.stat[EV_LIMIT] = 1'b1;
                end
            end
        end

        // remember a load that arrives mid-frame
        if (load_ev && s_q.busy)
            s_d.pend_load = 1'b1;
        if (load_now) begin
            // copy the counter, mark data valid
            s_d.shreg = {s_q.cnt, 1'b0};
            s_d.avail = 1'b1;
            s_d.pend_load = 1'b0;
            s_d.stat[EV_LOADED] = 1'b1;
        end
        if (xmit_ev && !s_q.busy)
            s_d.pend_xmit = 1'b1;

        // transmitter on pin clock edges
        if (trise) begin
            s_d.pulse = 1'b0;
            s_d.casc = 1'b0;
        end
        if (start_now) begin
            s_d.busy = 1'b1;
            s_d.pend_xmit = 1'b0;
            if (s_q.pin_s[PIN_LEN8]) begin
                s_d.shreg = {dword[9:2],
                    ~(^dword[9:2] ^ s_q.pin_s[PIN_EVEN]), 2'b00};
                s_d.bits_left = BITS_SHORT;
            end else begin
                s_d.shreg = {dword, ~(^dword ^ s_q.pin_s[PIN_EVEN])};
                s_d.bits_left = BITS_LONG;
            end
            s_d.ser = s_d.shreg[FRAME_W-1];
        end else if (trise && s_q.busy) begin
            if (s_q.bits_left > 4'h1) begin
                s_d.shreg = {s_q.shreg[FRAME_W-2:0], 1'b0};
                s_d.ser = s_q.shreg[FRAME_W-2];
                s_d.bits_left = s_q.bits_left - 4'h1;
            end else begin
                s_d.busy = 1'b0;
                s_d.avail = 1'b0;
                s_d.ser = 1'b0;
                s_d.casc = 1'b1;
                s_d.stat[EV_DONE] = 1'b1;
            end
        end else if (tfall && s_q.busy) begin
            s_d.pulse = 1'b1;
        end

        // register bus, answer on second cycle
        s_d.ack = (read | write) & ~s_q.ack;
        if (rd_go) begin
            s_d.rdata = 32'h0000_0000;
            if (hit(address, OFF_CTRL))
                s_d.rdata[CTRL_RUN_BIT] = s_q.run;
            else if (hit(address, OFF_STATUS))
                s_d.rdata = {13'h0000, s_q.pend_load, s_q.busy,
                    s_q.avail, 6'h00, s_q.cnt};
            else if (hit(address, OFF_IRQ_STAT))
                s_d.rdata[EV_W-1:0] = s_q.stat;
            else if (hit(address, OFF_IRQ_MASK))
                s_d.rdata[EV_W-1:0] = s_q.mask;
        end
        if (wr_ok) begin
            if (hit(address, OFF_CTRL))
                s_d.run = writedata[CTRL_RUN_BIT];
            if (hit(address, OFF_IRQ_MASK))
                s_d.mask = writedata[EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.run <= CTRL_RUN_RST;
            s_q.mask <= MASK_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // straight binary, par_out[9] is bit one
    assign par_out = s_q.cnt;
    assign ser_out = s_q.ser;
    assign pulse_chain = s_q.pulse;
    assign data_avail = s_q.avail;
    assign cascade_out = s_q.casc;
    assign irq = |(s_q.stat & s_q.mask);
    assign readdata = s_q.rdata;
    assign waitrequest = (read | write) & ~s_q.ack;

    ////////////////////////////////////////////////////////////////////
    // checks: pulse count per frame kept only for the assertions
    logic [3:0] pc_q;
    logic f8_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= 4'h0;
            f8_q <= 1'b0;
        end else if (ce) begin
            if (start_now) begin
                pc_q <= 4'h0;
                f8_q <= s_q.pin_s[PIN_LEN8];
            end else if (s_d.pulse && !s_q.pulse) begin
                pc_q <= pc_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_count_up_step: assert property (
        ce && cedge && !cnt_inhibit && s_q.pin_s[PIN_DIR]
        && s_q.cnt != CNT_MAX |=> s_q.cnt == $past(s_q.cnt) + 10'h001)
        else $error("counter did not step up");
    a_count_down_step: assert property (
        ce && cedge && !cnt_inhibit && !s_q.pin_s[PIN_DIR]
        && s_q.cnt != CNT_MIN |=> s_q.cnt == $past(s_q.cnt) - 10'h001)
        else $error("counter did not step down");
    a_hold_all_ones: assert property (
        s_q.cnt == CNT_MAX && s_q.pin_s[PIN_DIR] && !load_now
        |=> s_q.cnt == CNT_MAX)
        else $error("counter wrapped past all ones");
    a_hold_all_zeros: assert property (
        s_q.cnt == CNT_MIN && !s_q.pin_s[PIN_DIR] && !load_now
        |=> s_q.cnt == CNT_MIN)
        else $error("counter wrapped past all zeros");
    a_dir_change_hold: assert property (
        ce && cedge && s_q.pin_s[PIN_DIR] != s_q.dir_last
        |=> $stable(s_q.cnt))
        else $error("counted during direction change");
    a_load_copies: assert property (
        ce && load_now |=> s_q.avail && dword == $past(s_q.cnt))
        else $error("load did not copy counter");
    a_load_deferred: assert property (
        ce && load_ev && s_q.busy
        |=> s_q.pend_load && (s_q.busy || s_q.casc))
        else $error("mid-frame load not remembered");
    a_cascade_width: assert property (
        $rose(s_q.casc) |-> !s_q.avail ##0
        (s_q.casc throughout (!(ce && trise))[*1]))
        else $error("cascade ended early or data still valid");
    a_cascade_ends: assert property (
        ce && trise && s_q.casc |=> !s_q.casc)
        else $error("cascade longer than one clock");
    a_burst_length: assert property (
        $rose(s_q.casc) |-> pc_q == (f8_q ? BITS_SHORT : BITS_LONG))
        else $error("wrong pulse chain length");
    a_irq_follows: assert property (
        $rose(irq) |-> $past(|(s_d.stat & s_d.mask)))
        else $error("interrupt without unmasked event");

    c_short_frame: cover property ($rose(s_q.casc) && f8_q);
    c_long_frame: cover property ($rose(s_q.casc) && !f8_q);
    c_limit_hit: cover property ($rose(s_q.stat[EV_LIMIT]));
    c_deferred_load: cover property ($fell(s_q.pend_load) && s_q.avail);
endmodule
